// ---- include/sdmc_pkg.sv ----
// Shared constants, field positions and carrier types for the SCSI data and mode control block
package sdmc_pkg;
  // Register selects
  localparam logic [2:0] SEL_DATA  = 3'h0;
  localparam logic [2:0] SEL_ICR   = 3'h1;
  localparam logic [2:0] SEL_MODE  = 3'h2;
  localparam logic [2:0] SEL_CLEAR = 3'h7;
  // Mode register bits
  localparam int M_BLOCK  = 7;
  localparam int M_TARGET = 6;
  localparam int M_PCHK   = 5;
  localparam int M_PIRQ   = 4;
  localparam int M_EOPIRQ = 3;
  localparam int M_BUSMON = 2;
  localparam int M_DMA    = 1;
  localparam int M_ARB    = 0;
  // Initiator signal control bits
  localparam int I_RST  = 7;
  localparam int I_TEST = 6;
  localparam int I_LOST = 5;
  localparam int I_ACK  = 4;
  localparam int I_BSY  = 3;
  localparam int I_SEL  = 2;
  localparam int I_ATN  = 1;
  localparam int I_DBUS = 0;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  // Busy monitor window
  localparam int CLK_PERIOD_PS = 4000;
  localparam int BUSY_MIN_NS   = 400;
  localparam int BUSY_MAX_NS   = 1200;
  localparam int BUSY_MIN_CYC  = (BUSY_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BUSY_MAX_CYC  = (BUSY_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int BUSY_CNT_W    = 9;
  // Data buffer
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;
  // Control lines, logical sense (1 = asserted on the bus)
  typedef struct packed {
    logic rst;
    logic bsy;
    logic sel;
    logic atn;
    logic ack;
    logic req;
    logic msg;
    logic cd;
    logic io;
  } sdmc_ctl_t;
  typedef struct packed {
    sdmc_ctl_t  ctl;
    logic       par;
    logic [7:0] data;
  } sdmc_bus_t;
  // Host side, logical sense (1 = strobe active)
  typedef struct packed {
    logic       cs;
    logic       rd;
    logic       wr;
    logic       grant;
    logic       eop;
    logic [2:0] a;
    logic [7:0] d;
  } sdmc_host_t;
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_LOAD    = 4'h2,
    ST_STROBE  = 4'h4,
    ST_RELEASE = 4'h8
  } sdmc_xfer_t;
endpackage

// ---- rtl/sdmc_busmon.sv ----
// Busy monitor: flags an unexpected loss of BSY that lasts past the minimum window
`timescale 1ns/1ps
module sdmc_busmon (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic enable,
  input  wire logic bsy,
  output logic      err_set
);
  logic                                armed;
  logic [sdmc_pkg::BUSY_CNT_W-1:0]     low_cnt;
  localparam logic [sdmc_pkg::BUSY_CNT_W-1:0] MIN_CNT = sdmc_pkg::BUSY_MIN_CYC[sdmc_pkg::BUSY_CNT_W-1:0];

  // Armed only after BSY has been seen, so an idle bus never trips it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed   <= 1'b0;
      low_cnt <= '0;
      err_set <= 1'b0;
    end else if (ce) begin
      err_set <= 1'b0;
      if (!enable || bsy) begin
        armed   <= enable && bsy;
        low_cnt <= '0;
      end else if (armed) begin
        low_cnt <= low_cnt + 1'b1;
        if (low_cnt == MIN_CNT - 1'b1) begin
          err_set <= 1'b1;
          armed   <= 1'b0;
        end
      end
    end
  end

  AST_BUSY_WINDOW: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(err_set) |-> $past(low_cnt) == MIN_CNT - 1'b1 && $past(low_cnt) < sdmc_pkg::BUSY_MAX_CYC)
    else $error("busy error outside the drop window");
endmodule

// ---- rtl/sdmc_fifo.sv ----
// Synchronous FIFO between the DMA byte capture and the bus handshake engine
`timescale 1ns/1ps
module sdmc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr;
  logic [AW:0]      rptr;
  logic             push;
  logic             pop;

  assign in_ready  = (wptr[AW] == rptr[AW]) || (wptr[AW-1:0] != rptr[AW-1:0]);
  assign out_valid = (wptr != rptr);
  assign out_data  = mem[rptr[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= '0;
      rptr <= '0;
    end else if (ce) begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      if (pop) begin
        rptr <= rptr + 1'b1;
      end
    end
  end

  AST_FIFO_FULL_STALL: assert property (@(posedge clk) disable iff (!rst_n)
    (wptr[AW-1:0] == rptr[AW-1:0] && wptr[AW] != rptr[AW]) |-> !in_ready)
    else $error("fifo accepts data while full");
endmodule

// ---- rtl/sdmc_top.sv ----
// SCSI protocol controller: output data, live bus read, mode and initiator signal control
`timescale 1ns/1ps
module sdmc_top (
  input  wire logic       MCLK,
  input  wire logic       NRST,
  input  wire logic       CE,
  input  wire logic       CS_N,
  input  wire logic [2:0] REG_SELECT_LINES,
  input  wire logic       HOST_READ_STROBE_N,
  input  wire logic       HOST_WRITE_STROBE_N,
  input  wire logic       DMA_GRANT_N,
  input  wire logic       TRANSFER_END_IN_N,
  input  wire logic [7:0] D_I,
  output logic      [7:0] D_O,
  output logic            D_OE,
  output logic            IRQ,
  output logic            DMA_REQUEST_OUT,
  output logic            READY,
  input  wire logic [3:0] TGT_PHASE,
  input  wire logic [8:0] CTL_I,
  output logic      [8:0] CTL_O,
  output logic      [8:0] CTL_OE,
  input  wire logic [7:0] SDB_I,
  output logic      [7:0] SDB_O,
  output logic      [7:0] SDB_OE,
  input  wire logic       SDBP_I,
  output logic            SDBP_O,
  output logic            SDBP_OE
);
  logic [1:0]           rst_pipe;
  logic                 rst_n;
  sdmc_pkg::sdmc_host_t host_raw;
  sdmc_pkg::sdmc_host_t host_s1;
  sdmc_pkg::sdmc_host_t host;
  sdmc_pkg::sdmc_host_t host_prev;
  sdmc_pkg::sdmc_bus_t  bus_raw;
  sdmc_pkg::sdmc_bus_t  bus_s1;
  sdmc_pkg::sdmc_bus_t  bus;
  logic [3:0]           phase_s1;
  logic [3:0]           phase;
  logic [7:0]           mode;
  logic [7:0]           icr;
  logic [7:0]           odr;
  logic [7:0]           dma_byte;
  logic                 arb_ip;
  logic                 lost_arb;
  logic                 par_err;
  logic                 busy_err;
  logic                 irq_flag;
  logic                 eop_seen;
  logic                 dma_request_out;
  logic                 xfer_hs;
  sdmc_pkg::sdmc_xfer_t xfer_state;
  logic                 reg_io;
  logic                 wr_evt;
  logic                 rd_evt;
  logic                 eop_evt;
  logic                 byte_end;
  logic                 busy_set;
  logic                 par_bad;
  logic                 par_evt;
  logic                 clr_evt;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic                 fifo_pop;
  logic [7:0]           fifo_out_data;
  logic                 target;
  logic                 release_all;
  logic                 arb_drive;
  logic                 phase_ok;
  logic                 dbus_drive;
  logic [7:0]           next_d_o;
  sdmc_pkg::sdmc_ctl_t  next_ctl;
  localparam logic [7:0] BYTE_Z = sdmc_pkg::BYTE_ZERO;

  function automatic logic is_reg(input sdmc_pkg::sdmc_host_t h, input logic [2:0] sel);
    is_reg = h.cs && !h.grant && (h.a == sel);
  endfunction

  // Reset release through two flops
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  assign host_raw = '{cs: !CS_N, rd: !HOST_READ_STROBE_N, wr: !HOST_WRITE_STROBE_N, grant: !DMA_GRANT_N,
                      eop: !TRANSFER_END_IN_N, a: REG_SELECT_LINES, d: D_I};
  assign bus_raw  = '{ctl: ~CTL_I, par: !SDBP_I, data: ~SDB_I};

  // Pin synchronisers; the second stage is read, and host_prev holds it one cycle more for edge detection
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      host_s1   <= '0;
      host      <= '0;
      host_prev <= '0;
      bus_s1    <= '0;
      bus       <= '0;
      phase_s1  <= '0;
      phase     <= '0;
    end else if (CE) begin
      host_s1   <= host_raw;
      host      <= host_s1;
      host_prev <= host;
      bus_s1    <= bus_raw;
      bus       <= bus_s1;
      phase_s1  <= TGT_PHASE;
      phase     <= phase_s1;
    end
  end

  assign target   = mode[sdmc_pkg::M_TARGET];
  assign reg_io   = host.cs && !host.grant;
  assign wr_evt   = host.wr && !host_prev.wr && reg_io;
  assign rd_evt   = host.rd && !host_prev.rd && reg_io;
  assign clr_evt  = rd_evt && host.a == sdmc_pkg::SEL_CLEAR;
  assign par_bad  = !(^{bus.data, bus.par});
  assign par_evt  = rd_evt && host.a == sdmc_pkg::SEL_DATA && mode[sdmc_pkg::M_PCHK] && par_bad;
  assign eop_evt  = host.eop && host.grant && (host.rd || host.wr) && !eop_seen;
  // Normal mode ends a byte on grant release, block mode on write strobe release
  assign byte_end = mode[sdmc_pkg::M_DMA] &&
                    (mode[sdmc_pkg::M_BLOCK] ? (host_prev.wr && !host.wr && host.grant)
                                             : (host_prev.grant && !host.grant));

  // Mode register; the reset bit holds it cleared
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      mode <= sdmc_pkg::MODE_RESET;
    end else if (CE) begin
      if (icr[sdmc_pkg::I_RST]) begin
        mode <= sdmc_pkg::MODE_RESET;
      end else if (wr_evt && host.a == sdmc_pkg::SEL_MODE) begin
        mode <= host.d;
      end
    end
  end

  // Initiator signal control; bit 5 is status and never stored from a write
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      icr <= BYTE_Z;
    end else if (CE) begin
      if (wr_evt && host.a == sdmc_pkg::SEL_ICR) begin
        icr <= host.d & ~(8'h01 << sdmc_pkg::I_LOST);
      end else if (icr[sdmc_pkg::I_RST]) begin
        icr <= icr & ((8'h01 << sdmc_pkg::I_RST) | (8'h01 << sdmc_pkg::I_TEST));
      end else if (busy_err) begin
        icr <= icr & ~8'h3f;
      end
    end
  end

  // Output byte register
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      odr <= BYTE_Z;
    end else if (CE) begin
      if (wr_evt && host.a == sdmc_pkg::SEL_DATA) begin
        odr <= host.d;
      end else if (fifo_pop) begin
        odr <= fifo_out_data;
      end
    end
  end

  // DMA write byte captured while strobe and grant are both active
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      dma_byte <= BYTE_Z;
    end else if (CE && host.wr && host.grant) begin
      dma_byte <= host.d;
    end
  end

  sdmc_fifo #(
    .WIDTH (sdmc_pkg::FIFO_WIDTH),
    .DEPTH (sdmc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (MCLK),
    .rst_n     (rst_n),
    .ce        (CE),
    .in_valid  (byte_end),
    .in_ready  (fifo_in_ready),
    .in_data   (dma_byte),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  sdmc_busmon u_busmon (
    .clk     (MCLK),
    .rst_n   (rst_n),
    .ce      (CE),
    .enable  (mode[sdmc_pkg::M_BUSMON]),
    .bsy     (bus.ctl.bsy),
    .err_set (busy_set)
  );

  // Arbitration status
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      arb_ip   <= 1'b0;
      lost_arb <= 1'b0;
    end else if (CE) begin
      if (!mode[sdmc_pkg::M_ARB]) begin
        arb_ip   <= 1'b0;
        lost_arb <= 1'b0;
      end else begin
        if (!bus.ctl.bsy && !bus.ctl.sel) begin
          arb_ip <= 1'b1;
        end
        if (arb_ip && bus.ctl.sel && !icr[sdmc_pkg::I_SEL]) begin
          lost_arb <= 1'b1;
        end
      end
    end
  end

  // Sticky flags: a set in the same cycle as the clearing read wins
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      par_err  <= 1'b0;
      busy_err <= 1'b0;
      irq_flag <= 1'b0;
    end else if (CE) begin
      par_err  <= par_evt || (par_err && !clr_evt);
      busy_err <= busy_set || (busy_err && !clr_evt);
      irq_flag <= (par_evt && mode[sdmc_pkg::M_PIRQ])
               || (eop_evt && mode[sdmc_pkg::M_EOPIRQ])
               || busy_set
               || icr[sdmc_pkg::I_RST]
               || (irq_flag && !clr_evt);
    end
  end

  // End of process blocks further requests until DMA mode is dropped
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      eop_seen <= 1'b0;
    end else if (CE) begin
      if (!mode[sdmc_pkg::M_DMA]) begin
        eop_seen <= 1'b0;
      end else if (eop_evt) begin
        eop_seen <= 1'b1;
      end
    end
  end

  // DMA request: cleared by grant, withheld while the buffer is full
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      dma_request_out <= 1'b0;
    end else if (CE) begin
      if (!mode[sdmc_pkg::M_DMA] || eop_seen || eop_evt || host.grant) begin
        dma_request_out <= 1'b0;
      end else if (fifo_in_ready && !byte_end) begin
        dma_request_out <= 1'b1;
      end
    end
  end

  // Automatic handshake engine; target pulses REQ, initiator answers REQ with ACK
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      xfer_state <= sdmc_pkg::ST_IDLE;
      xfer_hs    <= 1'b0;
    end else if (CE) begin
      if (!mode[sdmc_pkg::M_DMA] || busy_err) begin
        xfer_state <= sdmc_pkg::ST_IDLE;
        xfer_hs    <= 1'b0;
      end else begin
        case (xfer_state)
          sdmc_pkg::ST_IDLE: begin
            if (fifo_out_valid && (target || bus.ctl.req)) begin
              xfer_state <= sdmc_pkg::ST_LOAD;
            end
          end
          sdmc_pkg::ST_LOAD: begin
            xfer_hs    <= 1'b1;
            xfer_state <= sdmc_pkg::ST_STROBE;
          end
          sdmc_pkg::ST_STROBE: begin
            if (target ? bus.ctl.ack : !bus.ctl.req) begin
              xfer_hs    <= 1'b0;
              xfer_state <= sdmc_pkg::ST_RELEASE;
            end
          end
          sdmc_pkg::ST_RELEASE: begin
            if (!target || !bus.ctl.ack) begin
              xfer_state <= sdmc_pkg::ST_IDLE;
            end
          end
          default: begin
            xfer_state <= sdmc_pkg::ST_IDLE;
            xfer_hs    <= 1'b0;
          end
        endcase
      end
    end
  end
  // Data is popped into the output byte one cycle before the strobe, giving settle time
  assign fifo_pop = (xfer_state == sdmc_pkg::ST_IDLE) && mode[sdmc_pkg::M_DMA] && !busy_err
                    && fifo_out_valid && (target || bus.ctl.req);

  // Bus drive decisions, logical sense
  assign release_all = icr[sdmc_pkg::I_TEST] || busy_err;
  assign arb_drive   = arb_ip && !lost_arb;
  assign phase_ok    = (bus.ctl.msg == phase[2]) && (bus.ctl.cd == phase[1]) && (bus.ctl.io == phase[0]);
  assign dbus_drive  = icr[sdmc_pkg::I_DBUS] && !arb_drive && (target || (phase_ok && !bus.ctl.io));

  always_comb begin
    next_ctl     = '0;
    next_ctl.rst = icr[sdmc_pkg::I_RST];
    next_ctl.bsy = icr[sdmc_pkg::I_BSY] || arb_drive;
    next_ctl.sel = icr[sdmc_pkg::I_SEL];
    next_ctl.atn = !target && icr[sdmc_pkg::I_ATN];
    next_ctl.ack = !target && (icr[sdmc_pkg::I_ACK] || xfer_hs);
    next_ctl.req = target && (phase[3] || xfer_hs);
    next_ctl.msg = target && phase[2];
    next_ctl.cd  = target && phase[1];
    next_ctl.io  = target && phase[0];
  end

  always_comb begin
    case (host.a)
      sdmc_pkg::SEL_DATA: next_d_o = bus.data;
      sdmc_pkg::SEL_ICR:  next_d_o = {icr[sdmc_pkg::I_RST], arb_ip, lost_arb, icr[4:0]};
      sdmc_pkg::SEL_MODE: next_d_o = mode;
      default:            next_d_o = BYTE_Z;
    endcase
  end

  // Registered pins; open-drain lines only pull low, so O stays zero
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      D_O             <= BYTE_Z;
      D_OE            <= 1'b0;
      IRQ             <= 1'b0;
      DMA_REQUEST_OUT <= 1'b0;
      READY           <= 1'b0;
      CTL_O           <= '0;
      CTL_OE          <= '0;
      SDB_O           <= BYTE_Z;
      SDB_OE          <= BYTE_Z;
      SDBP_O          <= 1'b0;
      SDBP_OE         <= 1'b0;
    end else if (CE) begin
      D_O             <= next_d_o;
      D_OE            <= host.rd && reg_io && !icr[sdmc_pkg::I_TEST];
      IRQ             <= irq_flag && !icr[sdmc_pkg::I_TEST];
      DMA_REQUEST_OUT <= dma_request_out && !icr[sdmc_pkg::I_TEST];
      READY           <= mode[sdmc_pkg::M_DMA] && mode[sdmc_pkg::M_BLOCK] && fifo_in_ready
                         && !eop_seen && !icr[sdmc_pkg::I_TEST];
      CTL_O           <= '0;
      CTL_OE          <= release_all ? '0 : next_ctl;
      SDB_O           <= BYTE_Z;
      SDB_OE          <= (!release_all && (dbus_drive || arb_drive)) ? odr : BYTE_Z;
      SDBP_O          <= 1'b0;
      SDBP_OE         <= !release_all && dbus_drive && !(^odr);
    end
  end

  AST_ODR_LOAD: assert property (@(posedge MCLK) disable iff (!rst_n)
    CE && wr_evt && host.a == sdmc_pkg::SEL_DATA |=> odr == $past(host.d))
    else $error("output byte not loaded by write");
  AST_LIVE_READ: assert property (@(posedge MCLK) disable iff (!rst_n)
    CE && host.rd && is_reg(host, sdmc_pkg::SEL_DATA) |=> D_O == $past(bus.data))
    else $error("live read does not show bus data");
  AST_PAR_LATCH: assert property (@(posedge MCLK) disable iff (!rst_n)
    CE && par_evt |=> par_err ##1 (par_err || $past(clr_evt)))
    else $error("parity error not latched");
  AST_MODE_RB: assert property (@(posedge MCLK) disable iff (!rst_n)
    CE && wr_evt && host.a == sdmc_pkg::SEL_MODE && !icr[sdmc_pkg::I_RST] |=> mode == $past(host.d))
    else $error("mode write not stored");
  AST_TARGET_ATN: assert property (@(posedge MCLK) disable iff (!rst_n)
    CE && target |=> !CTL_OE[5] && !CTL_OE[4])
    else $error("initiator lines driven in target role");
  AST_BUSY_REL: assert property (@(posedge MCLK) disable iff (!rst_n)
    CE && busy_err |=> CTL_OE == '0 && SDB_OE == BYTE_Z && SDBP_OE == 1'b0)
    else $error("bus driven during busy error");
  AST_RST_IRQ: assert property (@(posedge MCLK) disable iff (!rst_n)
    CE && icr[sdmc_pkg::I_RST] && !icr[sdmc_pkg::I_TEST] |=> irq_flag && mode == sdmc_pkg::MODE_RESET)
    else $error("reset bit did not interrupt and clear");
  AST_ARB_CLR: assert property (@(posedge MCLK) disable iff (!rst_n)
    CE && !mode[sdmc_pkg::M_ARB] |=> !arb_ip && !lost_arb)
    else $error("arbitration status stays after arbitrate bit cleared");
  AST_TEST_TRI: assert property (@(posedge MCLK) disable iff (!rst_n)
    CE && icr[sdmc_pkg::I_TEST] |=> !D_OE && !IRQ && CTL_OE == '0)
    else $error("outputs driven in test mode");
  AST_EOP_STOP: assert property (@(posedge MCLK) disable iff (!rst_n)
    CE && eop_seen |=> !dma_request_out && mode[sdmc_pkg::M_DMA] == $past(mode[sdmc_pkg::M_DMA]) || $past(wr_evt))
    else $error("request raised after end of process");

  COV_ARB_WON: cover property (@(posedge MCLK) disable iff (!rst_n) arb_ip && !lost_arb ##1 icr[sdmc_pkg::I_SEL]);
  COV_DMA_PUSH: cover property (@(posedge MCLK) disable iff (!rst_n) byte_end && fifo_in_ready);
  COV_HANDSHAKE: cover property (@(posedge MCLK) disable iff (!rst_n) xfer_state == sdmc_pkg::ST_RELEASE);
  COV_BUSY_ERR: cover property (@(posedge MCLK) disable iff (!rst_n) busy_set);
endmodule

// ---- verif/sdmc_scsi_dev.sv ----
// Far-side SCSI device model: drives data and parity, raises SEL, answers REQ with ACK
`timescale 1ns/1ps
module sdmc_scsi_dev (
  input  wire logic       clk,
  input  wire logic       drive,
  input  wire logic       bad_par,
  input  wire logic       sel,
  input  wire logic       req,
  input  wire logic [7:0] value,
  output logic      [7:0] sdb_oe,
  output logic            par_oe,
  output logic      [8:0] ctl_oe
);
  // Released lines go back to the terminator level, never hold the last byte
  always_ff @(posedge clk) begin
    sdb_oe <= drive ? value : 8'h00;
    par_oe <= drive & (~^value ^ bad_par);
    // Acting initiator: ACK follows REQ, so it drops only after REQ has dropped
    ctl_oe <= {2'h0, sel, 1'b0, req, 4'h0};
  end
endmodule

// ---- verif/sdmc_top_tb.sv ----
// Self-checking bench for the SCSI data and mode control block
`timescale 1ns/1ps
module sdmc_top_tb;
  logic       mclk = 1'b0;
  logic       nrst = 1'b0;
  logic       cs_n = 1'b1;
  logic       rd_n = 1'b1;
  logic       wr_n = 1'b1;
  logic [2:0] a    = 3'h0;
  logic [7:0] d_i  = 8'h00;
  logic       p_drive = 1'b0;
  logic [7:0] p_val   = 8'h00;
  logic       ce      = 1'b1;
  logic       gnt_n   = 1'b1;
  logic       eop_n   = 1'b1;
  logic       p_bad   = 1'b0;
  logic       p_sel   = 1'b0;
  logic [8:0] p_ctl;
  logic [7:0] q[$];
  logic [7:0] d_o, sdb_o, sdb_oe, p_sdb, rv, v;
  logic [8:0] ctl_o, ctl_oe;
  logic       d_oe, irq, dma_request_out, rdy, sdbp_o, sdbp_oe, p_par;
  int         seed, n_errors, n_tests, i;

  always #2 mclk = ~mclk;

  // Lines are terminated high: any driver pulls them low
  sdmc_top sdmc_top_i (
    .MCLK(mclk), .NRST(nrst), .CE(ce), .CS_N(cs_n), .REG_SELECT_LINES(a),
    .HOST_READ_STROBE_N(rd_n), .HOST_WRITE_STROBE_N(wr_n),
    .DMA_GRANT_N(gnt_n),
    .TRANSFER_END_IN_N(eop_n), .D_I(d_i), .D_O(d_o), .D_OE(d_oe), .IRQ(irq),
    .DMA_REQUEST_OUT(dma_request_out), .READY(rdy), .TGT_PHASE(4'h0), .CTL_I(~(ctl_oe | p_ctl)),
    .CTL_O(ctl_o), .CTL_OE(ctl_oe), .SDB_I(~(sdb_oe | p_sdb)), .SDB_O(sdb_o),
    .SDB_OE(sdb_oe), .SDBP_I(~(sdbp_oe | p_par)), .SDBP_O(sdbp_o), .SDBP_OE(sdbp_oe));

  sdmc_scsi_dev sdmc_scsi_dev_i (.clk(mclk), .drive(p_drive), .bad_par(p_bad), .sel(p_sel), .req(ctl_oe[3]),
    .value(p_val), .sdb_oe(p_sdb), .par_oe(p_par), .ctl_oe(p_ctl));

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Strobes stay low 4 cycles (5 for a read) and high 4 cycles to clear the synchronisers
  task automatic wr(input logic [2:0] ad, input logic [7:0] dv);
    cs_n <= 1'b0;
    a    <= ad;
    d_i  <= dv;
    wr_n <= 1'b0;
    cyc(4);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    cyc(4);
  endtask

  task automatic rd(input logic [2:0] ad, output logic [7:0] dv);
    cs_n <= 1'b0;
    a    <= ad;
    rd_n <= 1'b0;
    cyc(5);
    dv = d_o;
    chk({7'h0, d_oe}, 8'h01);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    cyc(4);
  endtask

  // DMA write byte; grant outlasts the strobe so block mode sees its strobe end
  task automatic dma(input logic [7:0] b, input logic e);
    q.push_back(b);
    gnt_n <= 1'b0;
    wr_n  <= 1'b0;
    eop_n <= !e;
    d_i   <= b;
    cyc(4);
    wr_n  <= 1'b1;
    eop_n <= 1'b1;
    cyc(2);
    gnt_n <= 1'b1;
    cyc(16);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    seed = 82117;
    cyc(3);
    nrst <= 1'b1;
    cyc(6);
    // Low mode bits stay clear so arbitration and DMA do not start
    for (i = 0; i < 6; i++) begin
      v = 8'($random(seed)) & 8'hf8;
      wr(sdmc_pkg::SEL_MODE, v);
      rd(sdmc_pkg::SEL_MODE, rv);
      chk(rv, v);
    end
    v = 8'($random(seed));
    wr(sdmc_pkg::SEL_DATA, v);
    wr(sdmc_pkg::SEL_MODE, 8'h40);
    wr(sdmc_pkg::SEL_ICR, 8'h11);
    chk(sdb_oe, v);
    chk({7'h0, sdbp_oe}, {7'h0, ~^v});
    chk({7'h0, ctl_oe[4]}, 8'h00);
    wr(sdmc_pkg::SEL_MODE, 8'h00);
    wr(sdmc_pkg::SEL_ICR, 8'h1e);
    chk(ctl_oe[7:0], 8'hf0);
    rd(sdmc_pkg::SEL_ICR, rv);
    chk(rv, 8'h1e);
    wr(sdmc_pkg::SEL_ICR, 8'h18);
    chk(ctl_oe[7:0], 8'h90);
    wr(sdmc_pkg::SEL_ICR, 8'h00);
    wr(sdmc_pkg::SEL_MODE, 8'h30);
    p_val   <= 8'($random(seed));
    p_drive <= 1'b1;
    p_bad   <= 1'b1;
    cyc(2);
    rd(sdmc_pkg::SEL_DATA, rv);
    chk(rv, p_val);
    chk({7'h0, irq}, 8'h01);
    p_drive <= 1'b0;
    p_bad   <= 1'b0;
    wr(sdmc_pkg::SEL_MODE, 8'h40);
    wr(sdmc_pkg::SEL_ICR, 8'h80);
    rd(sdmc_pkg::SEL_MODE, rv);
    chk(rv, 8'h00);
    chk({6'h0, irq, ctl_oe[8]}, 8'h03);
    wr(sdmc_pkg::SEL_ICR, 8'h00);
    rd(sdmc_pkg::SEL_CLEAR, rv);
    chk({7'h0, irq}, 8'h00);
    // Busy monitor: BSY seen, then dropped while ATN is still requested
    wr(sdmc_pkg::SEL_ICR, 8'h08);
    wr(sdmc_pkg::SEL_MODE, 8'h04);
    wr(sdmc_pkg::SEL_ICR, 8'h02);
    cyc(120);
    chk({6'h0, irq, ctl_oe[5]}, 8'h02);
    rd(sdmc_pkg::SEL_ICR, rv);
    chk(rv, 8'h00);
    rd(sdmc_pkg::SEL_CLEAR, rv);
    chk({7'h0, irq}, 8'h00);
    // Arbitration on a free bus, then lost to another SEL
    wr(sdmc_pkg::SEL_MODE, 8'h01);
    chk(sdb_oe, v);
    chk({7'h0, ctl_oe[7]}, 8'h01);
    rd(sdmc_pkg::SEL_ICR, rv);
    chk(rv, 8'h40);
    p_sel <= 1'b1;
    cyc(4);
    rd(sdmc_pkg::SEL_ICR, rv);
    chk(rv, 8'h60);
    p_sel <= 1'b0;
    wr(sdmc_pkg::SEL_MODE, 8'h00);
    rd(sdmc_pkg::SEL_ICR, rv);
    chk(rv, 8'h00);
    // DMA as target: one normal byte, then one block byte closed by end of process
    wr(sdmc_pkg::SEL_ICR, 8'h09);
    wr(sdmc_pkg::SEL_MODE, 8'h42);
    chk({6'h0, dma_request_out, rdy}, 8'h02);
    dma(8'($random(seed)), 1'b0);
    chk(sdb_oe, q.pop_front());
    wr(sdmc_pkg::SEL_MODE, 8'hca);
    chk({7'h0, rdy}, 8'h01);
    dma(8'($random(seed)), 1'b1);
    chk(sdb_oe, q.pop_front());
    chk({5'h0, irq, dma_request_out, rdy}, 8'h04);
    rd(sdmc_pkg::SEL_MODE, rv);
    chk(rv, 8'hca);
    wr(sdmc_pkg::SEL_MODE, 8'h40);
    rd(sdmc_pkg::SEL_CLEAR, rv);
    chk({6'h0, irq, dma_request_out}, 8'h00);
    chk(ctl_o[7:0] | sdb_o | {7'h0, ctl_o[8] | sdbp_o}, 8'h00);
    // A write while the clock enable is low must leave no trace
    ce <= 1'b0;
    wr(sdmc_pkg::SEL_MODE, 8'h10);
    ce <= 1'b1;
    rd(sdmc_pkg::SEL_MODE, rv);
    chk(rv, 8'h40);
    report_and_stop();
  end

  // The sequence needs well under 1000 cycles
  initial begin
    cyc(5000);
    n_errors++;
    report_and_stop();
  end
endmodule
